// ===== awf_consts.vh
`ifndef AWF_CONSTS_VH
`define AWF_CONSTS_VH
// ****************************************
// opcode layout
// ****************************************
`define AWF_OPC_HI 15
`define AWF_OPC_LO 10
`define AWF_OPC_VAL 6'h09
`define AWF_DEST_BIT 9
`define AWF_ACC_BIT 8
// ****************************************
// addressing
// ****************************************
`define AWF_ILO_MAX 8'h5F
`define AWF_ACC_SPLIT 8'h60
`define AWF_ACC_HIGH_BANK 4'hF
// ****************************************
// register offsets
// ****************************************
`define AWF_REG_CTRL 4'h0
`define AWF_REG_ACCUM 4'h4
`define AWF_REG_STATUS 4'h8
`define AWF_REG_INSN 4'hC
`define AWF_CTRL_RST 8'h00
// ****************************************
// phases, one-hot
// ****************************************
`define AWF_PH_IDLE 5'h01
`define AWF_PH_Q1 5'h02
`define AWF_PH_Q2 5'h04
`define AWF_PH_Q3 5'h08
`define AWF_PH_Q4 5'h10
`endif

// ===== awf_file_mem.v
`timescale 1ns/1ps
`include "awf_consts.vh"
module awf_file_mem #(
  parameter AW = 12,
  parameter DW = 8
) (
  input wire sysClk,
  input wire wrEn,
  input wire [AW-1:0] wrAddr,
  input wire [DW-1:0] wrData,
  input wire [AW-1:0] rdAddr,
  output reg [DW-1:0] rdData
);
  reg [DW-1:0] mem [0:(1<<AW)-1];
  // registered read, write-first not needed
  always @(posedge sysClk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule

// ===== awf_add_exec.v
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "awf_consts.vh"
// Notes on behaviour
// - opcode top six bits 001001, then destination, access bit, 8-bit file address.
// - add accumulator to file; destination 0 writes accumulator, 1 writes file.
// - access bit 0 uses access bank; 1 takes bank from bank select register.
// - access bit 0, extended set on, address <= 95: indexed literal offset addressing.
// - negative, overflow, carry, digit carry, zero updated for either destination.
// - one cycle of four phases: decode, read file, compute, write destination.
module awf_add_exec (
  input wire sys_clk,
  input wire nrst,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output wire busy
);
  // ****************************************
  // registers
  // ****************************************
  // execution phases, one-hot
  localparam PH_IDLE = `AWF_PH_IDLE;
  localparam PH_Q1 = `AWF_PH_Q1;
  localparam PH_Q2 = `AWF_PH_Q2;
  localparam PH_Q3 = `AWF_PH_Q3;
  localparam PH_Q4 = `AWF_PH_Q4;
  reg [7:0] ctrl; // [3:0] bank select, [4] extended set, [7:5] unused
  reg [7:0] accum;
  reg [4:0] status; // {N,OV,Z,DC,C}
  reg [15:0] insn;
  reg [7:0] fsrIdx; // index base for literal offset mode
  reg [4:0] phase;
  reg badOp;
  reg [7:0] operand;
  reg [11:0] effAddr;
  reg haveAw;
  reg haveW;
  reg [3:0] awAddr;
  reg [31:0] wData;
  reg [3:0] wStrb;
  wire [7:0] fileQ;
  wire memWr;
  wire [7:0] fAddr = insn[7:0];
  wire destFile = insn[`AWF_DEST_BIT];
  wire accBit = insn[`AWF_ACC_BIT];
  wire isAdd = insn[`AWF_OPC_HI:`AWF_OPC_LO] == `AWF_OPC_VAL;
  wire [8:0] wide = {1'b0, accum} + {1'b0, operand};
  wire [4:0] lowNib = {1'b0, accum[3:0]} + {1'b0, operand[3:0]};
  reg [11:0] next_effAddr;
  // ****************************************
  // address resolution
  // ****************************************
  always @* begin
    if (accBit) begin
      next_effAddr = {ctrl[3:0], fAddr};
    end else if (ctrl[4] && fAddr <= `AWF_ILO_MAX) begin
      next_effAddr = {4'h0, fsrIdx + fAddr};
    end else if (fAddr < `AWF_ACC_SPLIT) begin
      next_effAddr = {4'h0, fAddr};
    end else begin
      next_effAddr = {`AWF_ACC_HIGH_BANK, fAddr};
    end
  end
  // ****************************************
  // bus slave
  // ****************************************
  wire wrGo = haveAw && haveW && !s_axi_bvalid;
  assign s_axi_awready = !haveAw && !s_axi_bvalid;
  assign s_axi_wready = !haveW && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign busy = phase != PH_IDLE;
  assign memWr = (phase == PH_Q4) && isAdd && destFile;
  // write capture, response, and read answer
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      haveAw <= 1'b0;
      haveW <= 1'b0;
      awAddr <= 4'h0;
      wData <= 32'h00000000;
      wStrb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h00000000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        haveAw <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        haveW <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (wrGo) begin
        haveAw <= 1'b0;
        haveW <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (awAddr)
          `AWF_REG_CTRL, `AWF_REG_ACCUM, `AWF_REG_STATUS, `AWF_REG_INSN: begin
            s_axi_bresp <= (awAddr == `AWF_REG_INSN && busy) ? 2'h2 : 2'h0;
          end
          default: begin
            s_axi_bresp <= 2'h2;
          end
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        case (s_axi_araddr)
          `AWF_REG_CTRL: begin
            s_axi_rdata <= {16'h0000, fsrIdx, ctrl};
          end
          `AWF_REG_ACCUM: begin
            s_axi_rdata <= {24'h000000, accum};
          end
          `AWF_REG_STATUS: begin
            s_axi_rdata <= {25'h0000000, badOp, busy, status};
          end
          `AWF_REG_INSN: begin
            s_axi_rdata <= {16'h0000, insn};
          end
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  // ****************************************
  // four-phase execution
  // ****************************************
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= `AWF_CTRL_RST;
      fsrIdx <= 8'h00;
      accum <= 8'h00;
      status <= 5'h00;
      insn <= 16'h0000;
      phase <= PH_IDLE;
      badOp <= 1'b0;
      operand <= 8'h00;
      effAddr <= 12'h000;
    end else begin
      if (wrGo && awAddr == `AWF_REG_CTRL) begin
        if (wStrb[0]) ctrl <= wData[7:0];
        if (wStrb[1]) fsrIdx <= wData[15:8];
      end
      if (wrGo && awAddr == `AWF_REG_ACCUM && wStrb[0] && !busy) begin
        accum <= wData[7:0];
      end
      if (wrGo && awAddr == `AWF_REG_STATUS && wStrb[0] && !busy) begin
        status <= wData[4:0];
      end
      case (phase)
        PH_IDLE: begin
          if (wrGo && awAddr == `AWF_REG_INSN) begin
            if (wStrb[0]) insn[7:0] <= wData[7:0];
            if (wStrb[1]) insn[15:8] <= wData[15:8];
            phase <= PH_Q1;
          end
        end
        PH_Q1: begin
          badOp <= !isAdd;
          effAddr <= next_effAddr;
          phase <= PH_Q2;
        end
        PH_Q2: begin
          phase <= PH_Q3; // memory read issued
        end
        PH_Q3: begin
          operand <= fileQ;
          phase <= PH_Q4;
        end
        PH_Q4: begin
          if (isAdd) begin
            // {N,OV,Z,DC,C}
            status <= {wide[7], (accum[7] == operand[7]) && (wide[7] != accum[7]),
                       wide[7:0] == 8'h00, lowNib[4], wide[8]};
            if (!destFile) accum <= wide[7:0];
          end
          phase <= PH_IDLE;
        end
        default: begin
          phase <= PH_IDLE;
        end
      endcase
    end
  end
  // ****************************************
  // data memory file
  // ****************************************
  awf_file_mem #(
    .AW(12),
    .DW(8)
  ) uMem (
    .sysClk(sys_clk),
    .wrEn(memWr),
    .wrAddr(effAddr),
    .wrData(wide[7:0]),
    .rdAddr(effAddr),
    .rdData(fileQ)
  );
endmodule

// ===== awf_add_exec_assertions.sv
`timescale 1ns/1ps
module awf_chk (
  input wire sys_clk,
  input wire nrst,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire busy
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // one instruction holds busy for exactly four phases
  a_busy_four: assert property ($rose(busy) |-> busy[*4] ##1 !busy)
    else $error("busy length wrong");
  a_busy_cause: assert property ($rose(busy) |-> $rose(s_axi_bvalid))
    else $error("busy without write");
  a_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> ##1 s_axi_bvalid) else $error("write not answered");
  a_aw_held: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  a_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid repeated");
  a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_r_once: assert property (s_axi_rvalid && s_axi_rready && !s_axi_arvalid
    |=> !s_axi_rvalid) else $error("rvalid repeated");
  a_r_cause: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid))
    else $error("rvalid without read");
  // main scenarios
  cover property ($rose(busy));
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind awf_add_exec awf_chk u_chk (.*);

// ===== awf_host.sv
`timescale 1ns/1ps
module awf_host (
  input wire sys_clk,
  output logic [3:0] s_axi_awaddr = 0,
  output logic [3:0] s_axi_araddr = 0,
  output logic [31:0] s_axi_wdata = 0,
  output logic [3:0] s_axi_wstrb = 4'hF,
  output logic s_axi_awvalid = 0,
  output logic s_axi_wvalid = 0,
  output logic s_axi_bready = 0,
  output logic s_axi_arvalid = 0,
  output logic s_axi_rready = 0,
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire [1:0] s_axi_bresp,
  input wire [1:0] s_axi_rresp,
  input wire [31:0] s_axi_rdata
);
  logic [1:0] resp;
  logic [31:0] rdat;
  // one write, address and data offered together
  task wr(input logic [3:0] a, input logic [31:0] d);
    logic pa, pw;
    @(posedge sys_clk);
    pa = 1;
    pw = 1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      pa = pa && !s_axi_awready;
      pw = pw && !s_axi_wready;
    end while (pa || pw);
    while (!s_axi_bvalid) @(posedge sys_clk);
    resp = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  // one read
  task rd(input logic [3:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge sys_clk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge sys_clk); while (!s_axi_rvalid);
    resp = s_axi_rresp;
    rdat = s_axi_rdata;
    s_axi_rready <= 0;
  endtask
endmodule

// ===== tb_add_w_to_file_exec.sv
`timescale 1ns/1ps
module tb_add_w_to_file_exec;
  logic sys_clk = 0;
  logic nrst = 0;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, busy;
  int nErrors = 0;
  int checked = 0;
  logic [7:0] f0;
  always #50 sys_clk = ~sys_clk;
  // file memory powers up unknown: clear it so every sum is defined
  initial begin
    for (int i = 0; i < 4096; i++) u_dut.uMem.mem[i] = 8'h00;
  end
  awf_add_exec u_dut (.*);
  awf_host u_host (.*);
  // compare and count
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      nErrors++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task rc(input logic [3:0] a, input logic [31:0] e, input string n);
    u_host.rd(a);
    chk(n, u_host.rdat, e);
  endtask
  // issue one instruction and let its four phases pass
  task op(input logic [15:0] i);
    u_host.wr(4'hC, {16'h0, i});
    chk("busy", busy, 1);
    repeat (6) @(posedge sys_clk);
    chk("idle", busy, 0);
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", checked, nErrors);
    if (nErrors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    nrst <= 1;
    rc(4'h0, 0, "ctrl");
    u_host.rd(4'h2);
    chk("unmapped resp", u_host.resp, 2);
    $display("test reset done");
    u_host.wr(4'h4, 0);
    op(16'h2420);
    u_host.rd(4'h4);
    f0 = u_host.rdat[7:0];
    u_host.wr(4'h4, {24'h0, 8'hC2 - f0});
    op(16'h2620);
    u_host.wr(4'h4, 32'h17);
    op(16'h2520);
    rc(4'h4, 32'hD9, "bank sum");
    rc(4'h8, 32'h10, "negative");
    u_host.wr(4'h0, 32'h1010);
    u_host.wr(4'h4, 32'h3E);
    op(16'h2410);
    rc(4'h4, 0, "indexed sum");
    rc(4'h8, 32'h07, "carry zero");
    $display("test addressing done");
    u_host.wr(4'h0, 0);
    u_host.wr(4'h4, 32'h7E);
    op(16'h2620);
    rc(4'h4, 32'h7E, "accum kept");
    rc(4'h8, 32'h03, "file flags");
    op(16'h2420);
    rc(4'h4, 32'hBE, "file sum");
    rc(4'h8, 32'h18, "overflow");
    op(16'h2820);
    rc(4'h4, 32'hBE, "bad opcode");
    rc(4'h8, 32'h58, "bad flag");
    $display("test destination done");
    u_host.wr(4'hC, 32'h2420);
    u_host.wr(4'hC, 32'h2420);
    chk("busy resp", u_host.resp, 2);
    repeat (6) @(posedge sys_clk);
    rc(4'h4, 32'hFE, "single add");
    $display("test timing done");
    test_done;
  end
  // watchdog
  initial begin
    repeat (3000) @(posedge sys_clk);
    nErrors++;
    test_done;
  end
endmodule
